// ==== common/sah_pkg.sv ====
// Constants shared by the serial converter control block
package sah_pkg;
	localparam int          CODE_W        = 13;
	localparam logic [12:0] CODE_POS_FS   = 13'h0FFF;
	localparam logic [12:0] CODE_NEG_FS   = 13'h1000;
	localparam logic [12:0] CODE_ZERO     = 13'h0000;
	localparam int          SAMPLE_W      = 16;
	localparam int          CFG_BITS      = 5;
	localparam int          SAMPLE_HALVES = 3;
	localparam int          FIFO_DEPTH    = 32;
	localparam int          CNT_W         = 4;

	typedef enum logic [4:0] {
		ST_STANDBY = 5'b0_0001,
		ST_CONFIG  = 5'b0_0010,
		ST_SAMPLE  = 5'b0_0100,
		ST_CONVERT = 5'b0_1000,
		ST_DONE    = 5'b1_0000
	} sah_state_t;
endpackage

// ==== hdl/sah_adc_ctrl.sv ====
// Serial converter control: sample FIFO and the serial exchange engine
//
// Function
// R1: The host pulls select_shutdown_n low to open an exchange before clocking.
// R2: Raising select_shutdown_n abandons any conversion and enters standby.
// R3: The host raises select_shutdown_n after each conversion; one per select.
// R4: Configuration bits on the serial input are taken at each serial rise.
// R5: The serial output changes only on serial clock falls, one bit per clock.
// R6: The serial clock starts and paces conversion, one result bit per clock.
// R7: Inputs beyond the reference minus one step clamp to the extreme codes.
// R8: Codes span 8192 steps over twice the reference, one step each.
// R9: The input is sampled for one and a half serial clock periods first.
// R10: The conversion phase lasts 13 serial clocks, one per result bit.
// R11: The result is 13-bit two's complement, 0x0FFF to 0x1000 at full scale.
// R12: The sign bit goes out first, most significant bit leading.
// R13: The serial output is released whenever select is high.
`timescale 1ns/1ps

module sah_fifo
#(
	parameter int W     = 16,
	parameter int DEPTH = 32
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_bad_depth
			$error("sah_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   count_q;
	logic [AW:0]   count_d;
	logic          in_ready_q;
	wire           push = in_valid & in_ready_q;
	wire           pop  = out_ready & (count_q != '0);

	assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready  = in_ready_q;
	assign out_valid = (count_q != '0);
	assign out_data  = mem[rd_q];

	always_ff @(posedge clk)
	begin
		if (ce && push)
			mem[wr_q] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q       <= '0;
			rd_q       <= '0;
			count_q    <= '0;
			in_ready_q <= 1'b0;
		end
		else if (ce)
		begin
			wr_q       <= wr_q + AW'(push);
			rd_q       <= rd_q + AW'(pop);
			count_q    <= count_d;
			in_ready_q <= (count_d != (AW+1)'(DEPTH));
		end
	end
endmodule

module sah_adc_ctrl
#(
	parameter int CFG_W = sah_pkg::CFG_BITS,
	parameter int DEPTH = sah_pkg::FIFO_DEPTH
)
(
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic                       select_shutdown_n,
	input  wire logic                       sclk,
	input  wire logic                       sdi,
	input  wire logic [sah_pkg::SAMPLE_W-1:0] sample_data,
	input  wire logic                       sample_valid,
	output logic                            sample_ready,
	output logic                            sdo_o,
	output logic                            sdo_oe,
	output logic [CFG_W-1:0]                channel_cfg,
	output logic                            standby,
	output logic                            sample_missed
);
	localparam int CW = sah_pkg::CNT_W;

	generate
		if (CFG_W < 2 || CFG_W >= (1 << CW))
		begin : g_bad_cfg
			$error("sah_adc_ctrl configuration width out of range");
		end
	endgenerate

	// Clamp a signed sample, given in code steps, to the 13-bit range
	function automatic logic [sah_pkg::CODE_W-1:0] clamp_code
		(input logic signed [sah_pkg::SAMPLE_W-1:0] s);
		logic signed [sah_pkg::SAMPLE_W-1:0] hi;
		logic signed [sah_pkg::SAMPLE_W-1:0] lo;
		hi = $signed({{(sah_pkg::SAMPLE_W-sah_pkg::CODE_W){1'b0}},
			sah_pkg::CODE_POS_FS});
		lo = $signed({{(sah_pkg::SAMPLE_W-sah_pkg::CODE_W){1'b1}},
			sah_pkg::CODE_NEG_FS});
		if (s > hi)
			clamp_code = sah_pkg::CODE_POS_FS; // R7
		else if (s < lo)
			clamp_code = sah_pkg::CODE_NEG_FS; // R7
		else
			clamp_code = s[sah_pkg::CODE_W-1:0]; // R8 R11
	endfunction

	logic rst_s1_q;
	logic rst_n_q;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	logic [sah_pkg::SAMPLE_W-1:0] fifo_data;
	logic                         fifo_valid;
	wire                          take;

	sah_fifo #(
		.W     (sah_pkg::SAMPLE_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n_q),
		.ce        (ce),
		.in_data   (sample_data),
		.in_valid  (sample_valid),
		.in_ready  (sample_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (take)
	);

	sah_pkg::sah_state_t          state_q;
	sah_pkg::sah_state_t          state_d;
	logic [CW-1:0]                cnt_q;
	logic [CW-1:0]                cnt_d;
	logic                         sclk_q;
	logic [sah_pkg::CODE_W-1:0]   shift_q;
	logic [sah_pkg::CODE_W-1:0]   shift_d;
	logic [CFG_W-1:0]             cfg_q;
	logic                         sdo_q;
	logic                         sdo_d;
	logic                         oe_q;
	logic                         oe_d;
	logic                         missed_q;

	wire sel   = ~select_shutdown_n;
	wire rise  = sclk & ~sclk_q;
	wire fall  = ~sclk & sclk_q;
	wire edge_ = rise | fall;
	wire cfg_last = (cnt_q == CW'(CFG_W - 1));
	wire smp_last = (cnt_q == CW'(sah_pkg::SAMPLE_HALVES - 1));
	wire cnv_last = (cnt_q == CW'(sah_pkg::CODE_W - 1));
	wire [sah_pkg::CODE_W-1:0] code =
		fifo_valid ? clamp_code(fifo_data) : sah_pkg::CODE_ZERO;

	// Sampling closes on the third serial edge after configuration
	assign take = (state_q == sah_pkg::ST_SAMPLE) & edge_ & smp_last & sel; // R9

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		shift_d = shift_q;
		sdo_d   = sdo_q;
		oe_d    = oe_q;
		unique case (state_q)
			sah_pkg::ST_STANDBY:
			begin
				cnt_d = '0;
				if (sel)
					state_d = sah_pkg::ST_CONFIG;
			end
			sah_pkg::ST_CONFIG:
			begin
				if (rise)
				begin
					cnt_d = cnt_q + CW'(1);
					if (cfg_last)
					begin
						cnt_d   = '0;
						state_d = sah_pkg::ST_SAMPLE; // R6
					end
				end
			end
			sah_pkg::ST_SAMPLE:
			begin
				if (edge_)
					cnt_d = cnt_q + CW'(1); // R9
				if (take)
				begin
					sdo_d   = code[sah_pkg::CODE_W-1]; // R12 R5
					shift_d = {code[sah_pkg::CODE_W-2:0], 1'b0};
					oe_d    = 1'b1;
					cnt_d   = CW'(1);
					state_d = sah_pkg::ST_CONVERT;
				end
			end
			sah_pkg::ST_CONVERT:
			begin
				if (fall)
				begin
					sdo_d   = shift_q[sah_pkg::CODE_W-1]; // R5 R6
					shift_d = {shift_q[sah_pkg::CODE_W-2:0], 1'b0};
					cnt_d   = cnt_q + CW'(1);
					if (cnv_last)
						state_d = sah_pkg::ST_DONE; // R10
				end
			end
			sah_pkg::ST_DONE:
			begin
				cnt_d = cnt_q;
			end
		endcase
		if (!sel)
		begin
			state_d = sah_pkg::ST_STANDBY; // R2
			oe_d    = 1'b0; // R13
			sdo_d   = 1'b0;
			cnt_d   = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_q  <= sah_pkg::ST_STANDBY;
			cnt_q    <= '0;
			sclk_q   <= 1'b0;
			shift_q  <= '0;
			cfg_q    <= '0;
			sdo_q    <= 1'b0;
			oe_q     <= 1'b0;
			missed_q <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			sclk_q  <= sclk;
			shift_q <= shift_d;
			sdo_q   <= sdo_d;
			oe_q    <= oe_d;
			if (state_q == sah_pkg::ST_CONFIG && rise && sel)
				cfg_q <= {cfg_q[CFG_W-2:0], sdi}; // R4
			if (take)
				missed_q <= ~fifo_valid;
		end
	end

	assign sdo_o         = sdo_q;
	assign sdo_oe        = oe_q;
	assign channel_cfg   = cfg_q;
	assign standby       = (state_q == sah_pkg::ST_STANDBY);
	assign sample_missed = missed_q;
endmodule

// ==== sim/sah_chk_properties.sv ====
// Checker for serial exchange timing at the block pins
`timescale 1ns/1ps
module sah_chk
#(
	parameter int CFG_W = 5
)
(
	input wire logic             clk,
	input wire logic             resetn,
	input wire logic             select_shutdown_n,
	input wire logic             sclk,
	input wire logic             sdi,
	input wire logic             sdo_o,
	input wire logic             sdo_oe,
	input wire logic [CFG_W-1:0] channel_cfg,
	input wire logic             standby,
	input wire logic             sample_missed
);
	logic       sc_q;
	logic [4:0] rc_q;
	logic [4:0] fc_q;
	// Serial clock rises and falls seen since select went low
	always_ff @(posedge clk)
	begin
		sc_q <= sclk;
		rc_q <= select_shutdown_n ? 5'h00 : rc_q + 5'(sclk & !sc_q);
		fc_q <= select_shutdown_n ? 5'h00 : fc_q + 5'(sc_q & !sclk);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sel_release_a: assert property (
		select_shutdown_n |=> standby && !sdo_oe && !sdo_o)
		else $error("output kept after select high");
	leave_standby_a: assert property (
		standby && !select_shutdown_n |=> !standby)
		else $error("standby kept");
	cfg_shift_a: assert property (
		$changed(channel_cfg) && !$past(select_shutdown_n) |-> $past(sclk)
		&& !$past(sclk, 2) && channel_cfg == {$past(channel_cfg[CFG_W-2:0]),
		$past(sdi)}) else $error("bad config shift");
	first_bit_a: assert property (
		$rose(sdo_oe) |-> rc_q == CFG_W + 1 && !$past(sclk) && $past(sclk, 2))
		else $error("first bit misplaced");
	bit_fall_a: assert property (
		$past(sdo_oe) && $changed(sdo_o) && !$past(select_shutdown_n)
		|-> !$past(sclk) && $past(sclk, 2)) else $error("bit off a fall");
	bit_count_a: assert property (
		$past(sdo_oe) && $changed(sdo_o) && !$past(select_shutdown_n)
		|-> fc_q <= CFG_W + 13) else $error("too many bits");
	oe_hold_a: assert property (
		sdo_oe && !select_shutdown_n |=> sdo_oe) else $error("oe dropped");
	miss_zero_a: assert property (
		$rose(sdo_oe) && sample_missed |-> !sdo_o) else $error("sign set");
	exch_c: cover property ($rose(sdo_oe));
	abort_c: cover property (sdo_oe && select_shutdown_n);
	miss_c: cover property ($rose(sample_missed));
endmodule
bind sah_adc_ctrl sah_chk #(.CFG_W(CFG_W)) chk_u (
	.clk               (clk),
	.resetn            (resetn),
	.select_shutdown_n (select_shutdown_n),
	.sclk              (sclk),
	.sdi               (sdi),
	.sdo_o             (sdo_o),
	.sdo_oe            (sdo_oe),
	.channel_cfg       (channel_cfg),
	.standby           (standby),
	.sample_missed     (sample_missed)
);

// ==== sim/sah_host_model.sv ====
// Serial master model that runs one exchange per call of run
`timescale 1ns/1ps
module sah_host_model
(
	input  wire logic clk,
	input  wire logic sdo_o,
	input  wire logic sdo_oe,
	output logic      select_shutdown_n,
	output logic      sclk,
	output logic      sdi,
	output logic [12:0] code,
	output logic      done
);
	initial
	begin
		select_shutdown_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		code = 13'h0000;
		done = 1'b0;
	end
	// Clock stands low outside frames; nonzero stop aborts at that period
	task automatic run(logic [4:0] cfg, logic [4:0] stop);
		int p;
		select_shutdown_n = 1'b0;
		repeat (2) @(negedge clk);
		for (p = 0; p < 19 && (stop == 5'h00 || p != stop); p++)
		begin
			if (p >= 6)
				code = {code[11:0], sdo_oe ? sdo_o : 1'bx};
			// Released data line toggles so stale bits cannot pass
			sdi = p < 5 ? cfg[4 - p] : ~sdi;
			sclk = 1'b1;
			repeat (2) @(negedge clk);
			sclk = 1'b0;
			repeat (2) @(negedge clk);
		end
		done = p == 19;
		@(negedge clk);
		done = 1'b0;
		select_shutdown_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask
endmodule

// ==== sim/test_serial_adc_host_interface.sv ====
// Self-checking bench for the serial converter control block
`timescale 1ns/1ps
module test_serial_adc_host_interface;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        ce = 1'b1;
	logic [15:0] sample_data = 16'h0000;
	logic        sample_valid = 1'b0;
	logic        sample_ready, sdo_o, sdo_oe, standby, sample_missed;
	logic        select_shutdown_n, sclk, sdi, done;
	logic [4:0]  channel_cfg;
	logic [12:0] code;
	logic [18:0] exp_q[$];
	logic [18:0] e;
	int          mismatches = 0, samples_checked = 0, cyc = 0, i;
	int          seed = 64;
	localparam logic [15:0] TBL [6] = '{16'h7FFF, 16'h8000, 16'h0FFF,
		16'hF000, 16'hEFFF, 16'h1000};
	sah_adc_ctrl dut_u (
		.clk               (clk),
		.resetn            (resetn),
		.ce                (ce),
		.select_shutdown_n (select_shutdown_n),
		.sclk              (sclk),
		.sdi               (sdi),
		.sample_data       (sample_data),
		.sample_valid      (sample_valid),
		.sample_ready      (sample_ready),
		.sdo_o             (sdo_o),
		.sdo_oe            (sdo_oe),
		.channel_cfg       (channel_cfg),
		.standby           (standby),
		.sample_missed     (sample_missed)
	);
	sah_host_model host_u (
		.clk               (clk),
		.sdo_o             (sdo_o),
		.sdo_oe            (sdo_oe),
		.select_shutdown_n (select_shutdown_n),
		.sclk              (sclk),
		.sdi               (sdi),
		.code              (code),
		.done              (done)
	);
	initial forever #50 clk = ~clk;
	task automatic chk(string n, logic [15:0] x, logic [15:0] g);
		samples_checked++;
		if (g !== x)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, x, g);
		end
	endtask
	task automatic end_sim;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [12:0] clamp(logic [15:0] s);
		if ($signed(s) > 16'sh0FFF)
			return sah_pkg::CODE_POS_FS;
		if ($signed(s) < -16'sh1000)
			return sah_pkg::CODE_NEG_FS;
		return s[12:0];
	endfunction
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			mismatches++;
			end_sim();
		end
	end
	initial forever
	begin
		@(posedge done);
		e = exp_q.pop_front();
		chk("code", e[12:0], code);
		chk("cfg", e[17:13], channel_cfg);
		chk("missed", e[18], sample_missed);
	end
	initial
	begin
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		// A word offered while the clock enable is low must not be stored
		ce = 1'b0;
		sample_data = 16'h0555;
		sample_valid = 1'b1;
		repeat (2) @(negedge clk);
		ce = 1'b1;
		for (i = 0; i < 32; i++)
		begin
			chk("ready", 1, sample_ready);
			sample_data = i < 6 ? TBL[i] : 16'($random(seed));
			sample_valid = 1'b1;
			exp_q.push_back({1'b0, 5'($random(seed)), clamp(sample_data)});
			@(negedge clk);
		end
		// Word offered while full must be ignored
		sample_data = 16'h0123;
		@(negedge clk);
		sample_valid = 1'b0;
		chk("full", 0, sample_ready);
		$display("test fill done");
		for (i = 0; i < 32; i++)
			host_u.run(exp_q[0][17:13], 5'h00);
		chk("ready", 1, sample_ready);
		$display("test convert done");
		exp_q.push_back({1'b1, 5'h15, 13'h0000});
		host_u.run(5'h15, 5'h00);
		$display("test empty done");
		host_u.run(5'h0A, 5'h08);
		chk("standby", 1, standby);
		chk("oe", 0, sdo_oe);
		chk("left", 0, 16'(exp_q.size()));
		$display("test abort done");
		end_sim();
	end
endmodule
